// >>> design/fhs_filter.v
`include "fhs_consts.vh"
`default_nettype none

module fhs_filter #(
  parameter [`FHS_CNT_W-1:0] HOLD_CYC = 23'h000001
) (
  input  wire clk_sys,
  input  wire srst,
  input  wire raw_in,
  output reg  level,
  output wire held
);

  reg                  sync1;
  reg                  sync2;
  reg                  sync3;
  reg [`FHS_CNT_W-1:0] cnt;

  // A comparator may chatter at its threshold, so a change is only taken
  // once two late stages agree.
  always @(posedge clk_sys) begin
    if (srst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      level <= 1'b0;
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        level <= sync3;
      end
    end
  end

  // Persistence timer: any low on the filtered level restarts the interval.
  always @(posedge clk_sys) begin
    if (srst || !level) begin
      cnt <= {`FHS_CNT_W{1'b0}}; // RULE_15
    end else if (cnt != HOLD_CYC) begin
      cnt <= cnt + 23'h000001; // RULE_15
    end
  end

  assign held = (cnt == HOLD_CYC);

endmodule // fhs_filter

`default_nettype wire

// >>> design/fhs_supervisor.v
`include "fhs_consts.vh"
`default_nettype none

module fhs_supervisor #(
  parameter [`FHS_CNT_W-1:0] OC_PERSIST_CYC  = `FHS_N_OC_PERSIST,
  parameter [`FHS_CNT_W-1:0] COMP_MAX_CYC    = `FHS_N_COMP_MAX,
  parameter [`FHS_CNT_W-1:0] HICCUP_CYC      = `FHS_N_HICCUP,
  parameter [`FHS_CNT_W-1:0] HICCUP_LONG_CYC = `FHS_N_HICCUP_LONG
) (
  input  wire clk_sys,
  input  wire srst,
  input  wire period_start,
  input  wire pwm_request,
  input  wire cs_over_limit,
  input  wire fb_over_ov,
  input  wire ovp_over_ov,
  input  wire fb_under_uv,
  input  wire fb_ov_released,
  input  wire fb_uv_released,
  input  wire comp_clamped,
  input  wire comp_over_max,
  input  wire ss_over_fb,
  input  wire ss_at_fb,
  input  wire ss_ramp_done,
  input  wire supply_uvlo,
  input  wire power_good_flag_in,
  output wire pwm_gate,
  output reg  hiccup_active,
  output reg  hiccup_long,
  output reg  soft_start,
  output reg  ss_discharge_en,
  output reg  recovery_active,
  output reg  oc_streak,
  output wire power_good_flag_out,
  output reg  power_good_flag_oe
);

  localparam [`FHS_CNT_W-1:0] OV_DLY_CYC = `FHS_N_PG_OV_DLY;
  localparam [`FHS_CNT_W-1:0] FB_DLY_CYC = `FHS_N_PG_FB_DLY;
  localparam [`FHS_CNT_W-1:0] OVP_CYC    = `FHS_N_OVP_HOLD;
  localparam [`FHS_CNT_W-1:0] ONE_CYC    = 23'h000001;

  wire oc_lvl;
  wire ov_both_held;
  wire uv_lvl;
  wire uv_held;
  wire rel_held;
  wire ovp_held;
  wire comp_max_held;
  wire clamp_lvl;
  wire ss_over_lvl;
  wire ss_at_lvl;
  wire ramp_lvl;
  wire uvlo_lvl;

  //////////////////////////////////////////////////////////////////////////
  // Comparator conditioning.

  fhs_filter #(.HOLD_CYC(ONE_CYC)) u_oc (
    .clk_sys (clk_sys),
    .srst    (srst),
    .raw_in  (cs_over_limit),
    .level   (oc_lvl),
    .held    ()
  );

  // Both comparators are glitch-free levels, so their product is safe to
  // synchronise as one signal.
  fhs_filter #(.HOLD_CYC(OV_DLY_CYC)) u_ov_both (
    .clk_sys (clk_sys),
    .srst    (srst),
    .raw_in  (fb_over_ov & ovp_over_ov), // RULE_08
    .level   (),
    .held    (ov_both_held) // RULE_10
  );

  fhs_filter #(.HOLD_CYC(FB_DLY_CYC)) u_uv (
    .clk_sys (clk_sys),
    .srst    (srst),
    .raw_in  (fb_under_uv), // RULE_08
    .level   (uv_lvl),
    .held    (uv_held) // RULE_10
  );

  fhs_filter #(.HOLD_CYC(FB_DLY_CYC)) u_release (
    .clk_sys (clk_sys),
    .srst    (srst),
    .raw_in  (fb_ov_released & fb_uv_released), // RULE_09
    .level   (),
    .held    (rel_held) // RULE_10
  );

  fhs_filter #(.HOLD_CYC(OVP_CYC)) u_ovp (
    .clk_sys (clk_sys),
    .srst    (srst),
    .raw_in  (ovp_over_ov),
    .level   (),
    .held    (ovp_held) // RULE_14
  );

  fhs_filter #(.HOLD_CYC(COMP_MAX_CYC)) u_comp_max (
    .clk_sys (clk_sys),
    .srst    (srst),
    .raw_in  (comp_over_max),
    .level   (),
    .held    (comp_max_held) // RULE_05
  );

  fhs_filter #(.HOLD_CYC(ONE_CYC)) u_clamp (
    .clk_sys (clk_sys),
    .srst    (srst),
    .raw_in  (comp_clamped),
    .level   (clamp_lvl),
    .held    ()
  );

  fhs_filter #(.HOLD_CYC(ONE_CYC)) u_ss_over (
    .clk_sys (clk_sys),
    .srst    (srst),
    .raw_in  (ss_over_fb),
    .level   (ss_over_lvl),
    .held    ()
  );

  fhs_filter #(.HOLD_CYC(ONE_CYC)) u_ss_at (
    .clk_sys (clk_sys),
    .srst    (srst),
    .raw_in  (ss_at_fb),
    .level   (ss_at_lvl),
    .held    ()
  );

  fhs_filter #(.HOLD_CYC(ONE_CYC)) u_ramp (
    .clk_sys (clk_sys),
    .srst    (srst),
    .raw_in  (ss_ramp_done),
    .level   (ramp_lvl),
    .held    ()
  );

  fhs_filter #(.HOLD_CYC(ONE_CYC)) u_uvlo (
    .clk_sys (clk_sys),
    .srst    (srst),
    .raw_in  (supply_uvlo),
    .level   (uvlo_lvl),
    .held    ()
  );

  //////////////////////////////////////////////////////////////////////////
  // Cycle-by-cycle limit and overcurrent persistence.

  reg                  oc_cut;
  reg                  oc_in_period;
  reg                  oc_prev_hit;
  reg [`FHS_CNT_W-1:0] oc_timer;
  reg [2:0]            hs_state;
  wire                 running;
  wire                 oc_cur;

  assign running = (hs_state == `FHS_HS_RUN);
  assign oc_cur  = oc_in_period | oc_lvl;

  // The pulse is blanked through the end of the period, since the sense
  // comparator drops again once the switch opens.
  assign pwm_gate = pwm_request & running & ~oc_cut & ~oc_lvl; // RULE_01

  always @(posedge clk_sys) begin
    if (srst) begin
      oc_cut       <= 1'b0;
      oc_in_period <= 1'b0;
      oc_prev_hit  <= 1'b0;
      oc_streak    <= 1'b0;
    end else begin
      oc_cut       <= oc_lvl | (oc_cut & ~period_start); // RULE_01
      oc_in_period <= oc_lvl | (oc_in_period & ~period_start);
      if (!running) begin
        oc_prev_hit <= 1'b0;
        oc_streak   <= 1'b0;
      end else if (period_start) begin
        oc_prev_hit <= oc_cur;
        if (oc_cur) begin
          oc_streak <= 1'b1;
        end else if (!oc_prev_hit) begin
          oc_streak <= 1'b0; // RULE_04
        end else begin
          oc_streak <= 1'b1; // RULE_03
        end
      end
    end
  end

  // Time is measured in clock cycles rather than periods so the 1.5 ms
  // window does not depend on the switching frequency.
  always @(posedge clk_sys) begin
    if (srst || !oc_streak) begin
      oc_timer <= {`FHS_CNT_W{1'b0}}; // RULE_15
    end else if (oc_timer != OC_PERSIST_CYC) begin
      oc_timer <= oc_timer + ONE_CYC; // RULE_02
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Hiccup sequencer.

  reg [2:0]            next_hs_state;
  reg [`FHS_CNT_W-1:0] hic_cnt;
  wire                 trig_long;
  wire                 trig_short;
  wire                 hic_done;

  assign trig_long  = ovp_held | uvlo_lvl; // RULE_11 RULE_14
  assign trig_short = (oc_timer == OC_PERSIST_CYC) | comp_max_held; // RULE_02 RULE_05
  assign hic_done   = hiccup_long ? (hic_cnt == HICCUP_LONG_CYC - ONE_CYC)
                                  : (hic_cnt == HICCUP_CYC - ONE_CYC);

  always @* begin
    next_hs_state = hs_state;
    case (hs_state)
      `FHS_HS_RUN: begin
        if (trig_long || trig_short) begin
          next_hs_state = `FHS_HS_OFF;
        end
      end
      `FHS_HS_OFF: begin
        if (hic_done) begin
          next_hs_state = `FHS_HS_START;
        end
      end
      `FHS_HS_START: begin
        next_hs_state = `FHS_HS_RUN;
      end
      default: begin
        next_hs_state = `FHS_HS_RUN;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      hs_state      <= `FHS_HS_RUN;
      hic_cnt       <= {`FHS_CNT_W{1'b0}}; // RULE_15
      hiccup_active <= 1'b0;
      hiccup_long   <= 1'b0;
    end else begin
      hs_state      <= next_hs_state;
      hiccup_active <= (next_hs_state == `FHS_HS_OFF);
      if (running && next_hs_state == `FHS_HS_OFF) begin
        hic_cnt     <= {`FHS_CNT_W{1'b0}};
        hiccup_long <= trig_long; // RULE_11
      end else if (hs_state == `FHS_HS_OFF) begin
        hic_cnt <= hic_cnt + ONE_CYC; // RULE_02
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Feedback recovery of the soft-start reference.

  reg [2:0] rs_state;
  reg [2:0] next_rs_state;
  wire      rec_start;

  assign rec_start = clamp_lvl & uv_lvl; // RULE_06

  always @* begin
    next_rs_state = rs_state;
    case (rs_state)
      `FHS_RS_IDLE: begin
        if (rec_start) begin
          next_rs_state = `FHS_RS_DIS; // RULE_06
        end
      end
      `FHS_RS_DIS: begin
        if (ss_at_lvl) begin
          next_rs_state = `FHS_RS_SS; // RULE_06
        end
      end
      `FHS_RS_SS: begin
        if (ss_over_lvl && clamp_lvl) begin
          next_rs_state = `FHS_RS_DIS; // RULE_07
        end else if (ramp_lvl) begin
          next_rs_state = `FHS_RS_IDLE;
        end
      end
      default: begin
        next_rs_state = `FHS_RS_IDLE;
      end
    endcase
    if (!running || next_hs_state != `FHS_HS_RUN) begin
      next_rs_state = `FHS_RS_IDLE;
    end
  end

  // A hiccup start and a recovery restart both request one soft start.
  always @(posedge clk_sys) begin
    if (srst) begin
      rs_state        <= `FHS_RS_IDLE;
      ss_discharge_en <= 1'b0;
      recovery_active <= 1'b0;
      soft_start      <= 1'b0;
    end else begin
      rs_state        <= next_rs_state;
      ss_discharge_en <= (next_rs_state == `FHS_RS_DIS); // RULE_06
      recovery_active <= (next_rs_state != `FHS_RS_IDLE);
      soft_start      <= (hs_state == `FHS_HS_START) ||
                         (rs_state == `FHS_RS_DIS && next_rs_state == `FHS_RS_SS);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Power-good flag; the pin reads back nothing this block needs, and the
  // nMOS only ever pulls low while the output is good.

  assign power_good_flag_out = 1'b0;

  always @(posedge clk_sys) begin
    if (srst) begin
      power_good_flag_oe <= 1'b0;
    end else if (power_good_flag_oe) begin
      if (ov_both_held || uv_held) begin
        power_good_flag_oe <= 1'b0; // RULE_08
      end
    end else if (rel_held && !ov_both_held && !uv_held) begin
      power_good_flag_oe <= 1'b1; // RULE_09
    end
  end

endmodule // fhs_supervisor

`default_nettype wire

// >>> inc/fhs_consts.vh
// Functional notes
// RULE_01: An overcurrent sample ends what is left of the current PWM pulse at once.
// RULE_02: Overcurrent counted in every period for 1.5 ms starts a 40 ms hiccup, then a soft start.
// RULE_03: A clean period right after an overcurrent period still counts as an overcurrent period.
// RULE_04: The overcurrent persistence count clears only after two clean periods in a row.
// RULE_05: The compensation node above its maximum clamp for over 1.5 ms starts a hiccup.
// RULE_06: Clamp plus feedback 100 mV low enables the fast reference discharge until it meets feedback.
// RULE_07: A reference 100 mV above feedback during precharged soft start re-enters recovery; the code also requires the clamp.
// RULE_08: The power-good flag goes to fault on feedback and overvoltage sense high, or feedback low.
// RULE_09: The flag returns to good only once the hysteresis comparators report release.
// RULE_10: Feedback faults act on the flag after 5 us, overvoltage-input faults after 90 ns.
// RULE_11: Secondary supply undervoltage selects the 200 ms hiccup instead of the 40 ms one.
// RULE_12: The other party moves the reference for tracking only after secondary handover.
// RULE_13: For remote shutdown the other party pulls the reference to 0 V.
// RULE_14: Overvoltage sense held high for 200 us starts a 200 ms hiccup.
// RULE_15: All intervals are counted on the one system clock and every counter clears on reset.
`ifndef FHS_CONSTS_VH
`define FHS_CONSTS_VH

`define FHS_CLK_MHZ        20
`define FHS_CNT_W          23

`define FHS_T_OC_PERSIST_US  1500
`define FHS_T_COMP_MAX_US    1500
`define FHS_T_OVP_HOLD_US    200
`define FHS_T_PG_FB_DLY_NS   5000
`define FHS_T_PG_OV_DLY_NS   90
`define FHS_T_HICCUP_MS      40
`define FHS_T_HICCUP_LONG_MS 200

// Cycle counts at the 20 MHz clock, sized to the counters; 90 ns rounds up to two cycles.
`define FHS_N_OC_PERSIST  23'h007530
`define FHS_N_COMP_MAX    23'h007530
`define FHS_N_OVP_HOLD    23'h000fa0
`define FHS_N_PG_FB_DLY   23'h000064
`define FHS_N_PG_OV_DLY   23'h000002
`define FHS_N_HICCUP      23'h0c3500
`define FHS_N_HICCUP_LONG 23'h3d0900

`define FHS_HS_RUN   3'b001
`define FHS_HS_OFF   3'b010
`define FHS_HS_START 3'b100

`define FHS_RS_IDLE  3'b001
`define FHS_RS_DIS   3'b010
`define FHS_RS_SS    3'b100

`endif

// >>> verif/fhs_partner.sv
`default_nettype none
module fhs_partner (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic [1:0] oc_mode,
  output var  logic       period_start,
  output var  logic       pwm_request,
  output var  logic       cs_over_limit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ph;
  logic [2:0] pc;
  // Ten-cycle period, six-cycle on time; current trips only while on, as in a real stage.
  // The stage never moves the reference, so it cannot disturb the secondary handover.
  always @(posedge clk_sys) begin
    ph <= (srst || ph == 4'h9) ? 4'h0 : ph + 4'h1;
    if (srst) pc <= 3'h0;
    else if (ph == 4'h9) pc <= (pc == 3'h5) ? 3'h0 : pc + 3'h1;
  end
  assign period_start = !srst && ph == 4'h0;
  assign pwm_request = !srst && ph < 4'h6;
  assign cs_over_limit = pwm_request && (oc_mode == 2'h1 || (oc_mode == 2'h2 && pc[0])
    || (oc_mode == 2'h3 && (pc == 3'h0 || pc == 3'h3)));
endmodule // fhs_partner
`default_nettype wire

// >>> verif/fhs_properties.sv
`default_nettype none
module fhs_properties #(
  parameter int HICCUP_CYC      = 32'h32,
  parameter int HICCUP_LONG_CYC = 32'h50
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic cs_over_limit,
  input wire logic fb_over_ov,
  input wire logic ovp_over_ov,
  input wire logic fb_under_uv,
  input wire logic fb_ov_released,
  input wire logic fb_uv_released,
  input wire logic ss_at_fb,
  input wire logic supply_uvlo,
  input wire logic period_start,
  input wire logic oc_streak,
  input wire logic pwm_gate,
  input wire logic hiccup_active,
  input wire logic hiccup_long,
  input wire logic soft_start,
  input wire logic ss_discharge_en,
  input wire logic recovery_active,
  input wire logic power_good_flag_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  int hc;
  int uc;
  // Counters, because these spans are far beyond what a repetition may unroll.
  always @(posedge clk_sys) begin
    hc <= (srst || !hiccup_active) ? 0 : hc + 1;
    uc <= (srst || !fb_under_uv) ? 0 : ((uc < 200) ? uc + 1 : uc);
  end
  //////////////////////////////
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_oc_cut: assert property (cs_over_limit [*6] |-> !pwm_gate)
    else $error("pulse not cut");
  a_hiccup_quiet: assert property (hiccup_active |-> !pwm_gate && !ss_discharge_en)
    else $error("activity in hiccup");
  a_hiccup_len: assert property ($fell(hiccup_active) |->
    hc == (hiccup_long ? HICCUP_LONG_CYC : HICCUP_CYC))
    else $error("hiccup length wrong");
  a_restart_pulse: assert property ($fell(hiccup_active) |-> ##[0:1] soft_start)
    else $error("no soft start after hiccup");
  a_uvlo_long: assert property (supply_uvlo [*6] ##0 $rose(hiccup_active) |->
    hiccup_long)
    else $error("short hiccup under uvlo");
  a_disch_rec: assert property ($rose(ss_discharge_en) |-> recovery_active)
    else $error("discharge outside recovery");
  a_disch_end: assert property (ss_discharge_en ##1 ss_at_fb [*7] |-> !ss_discharge_en)
    else $error("discharge past feedback");
  a_pg_ov: assert property ((fb_over_ov && ovp_over_ov) [*8] |->
    !power_good_flag_oe)
    else $error("flag good during overvoltage");
  a_pg_uv: assert property (uc >= 106 |-> !power_good_flag_oe)
    else $error("flag good during undervoltage");
  a_pg_back: assert property ($rose(power_good_flag_oe) |->
    $past(fb_ov_released && fb_uv_released, 8))
    else $error("flag good without release");
  // Outside a hiccup the streak may only end on a period boundary.
  a_streak_fall: assert property ($fell(oc_streak) && !hiccup_active |->
    $past(period_start))
    else $error("streak cleared off a period boundary");
endmodule // fhs_properties
`default_nettype wire

// >>> verif/tb_fhs_supervisor.sv
`default_nettype none
module tb_fhs_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [22:0] HS = 23'h32;
  localparam logic [22:0] HL = 23'h50;
  logic        clk_sys = 0, srst = 1, fb_over_ov = 0, ovp_over_ov = 0, fb_under_uv = 0;
  logic        comp_clamped = 0, comp_over_max = 0, ss_over_fb = 0, ss_at_fb = 0;
  logic        fb_ov_released = 1, fb_uv_released = 1, ss_ramp_done = 0, supply_uvlo = 0;
  logic        poe = 0, pdis = 0;
  logic [1:0]  oc_mode = 0;
  logic [31:0] seed = 32'heeb03d8f;
  logic [31:0] exq[$];
  int          mismatches = 0, cmp_count = 0, hc = 0, cyc = 0;
  wire logic   period_start, pwm_request, cs_over_limit, pwm_gate, hiccup_active, hiccup_long;
  wire logic   soft_start, ss_discharge_en, recovery_active, oc_streak, power_good_flag_out;
  wire logic   power_good_flag_oe, pg_pin;
  // Pull-up on the open-drain flag pin.
  assign pg_pin = power_good_flag_oe ? power_good_flag_out : 1'b1;
  fhs_supervisor #(.OC_PERSIST_CYC(23'h3c), .COMP_MAX_CYC(23'h14), .HICCUP_CYC(HS),
    .HICCUP_LONG_CYC(HL)) fhs_supervisor_inst (.*, .power_good_flag_in(pg_pin));
  fhs_partner fhs_partner_inst (.*);
  initial forever #25 clk_sys = ~clk_sys;
  //////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task ww(input bit s, input logic v);
    for (int i = 0; i < 5000 && (s ? ss_discharge_en : hiccup_active) !== v; i++)
      @(posedge clk_sys);
  endtask
  task chk(input logic [31:0] got);
    logic [31:0] e;
    e = exq.size() ? exq.pop_front() : 32'hffffffff;
    cmp_count++;
    if (got !== e) begin
      mismatches++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, got);
    end
  endtask
  task end_sim;
    mismatches += exq.size();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  always @(posedge clk_sys) begin
    if (srst) begin
      hc = 0;
      poe = 0;
      pdis = 0;
    end else begin
      if (hiccup_active === 1'b1) hc++;
      else if (hc != 0) begin
        chk({8'h01, 7'h00, hiccup_long, 16'(hc)});
        hc = 0;
      end
      if (power_good_flag_oe !== poe) chk({8'h02, 23'h0, power_good_flag_oe});
      if (ss_discharge_en !== pdis) chk({8'h03, 23'h0, ss_discharge_en});
      poe = power_good_flag_oe;
      pdis = ss_discharge_en;
    end
  end
  //////////////////////////////
  initial begin
    wt(4);
    srst <= 0;
    exq.push_back({8'h02, 24'h1});
    wt(150);
    oc_mode <= 2'h2;
    exq.push_back({8'h01, 8'h00, 16'(HS)});
    ww(0, 1);
    oc_mode <= 2'h0;
    wt(100);
    // Two clean periods between hits must keep the converter out of hiccup.
    oc_mode <= 2'h3;
    wt(400);
    oc_mode <= 2'h0;
    wt(20);
    // Secondary supply undervoltage: supply_uvlo high must select the long hiccup.
    supply_uvlo <= 1;
    exq.push_back({8'h01, 8'h01, 16'(HL)});
    ww(0, 1);
    supply_uvlo <= 0;
    wt(120);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      comp_over_max <= 1;
      wt(1 + seed[3:0] % 15);
      comp_over_max <= 0;
      wt(20);
    end
    comp_over_max <= 1;
    exq.push_back({8'h01, 8'h00, 16'(HS)});
    ww(0, 1);
    comp_over_max <= 0;
    wt(120);
    ovp_over_ov <= 1;
    exq.push_back({8'h01, 8'h01, 16'(HL)});
    ww(0, 1);
    ovp_over_ov <= 0;
    wt(120);
    fb_over_ov <= 1;
    ovp_over_ov <= 1;
    fb_ov_released <= 0;
    exq.push_back({8'h02, 24'h0});
    wt(10);
    fb_over_ov <= 0;
    ovp_over_ov <= 0;
    fb_ov_released <= 1;
    exq.push_back({8'h02, 24'h1});
    wt(150);
    fb_under_uv <= 1;
    wt(50);
    fb_under_uv <= 0;
    wt(20);
    fb_under_uv <= 1;
    fb_uv_released <= 0;
    exq.push_back({8'h02, 24'h0});
    wt(150);
    fb_under_uv <= 0;
    fb_uv_released <= 1;
    exq.push_back({8'h02, 24'h1});
    wt(150);
    comp_clamped <= 1;
    fb_under_uv <= 1;
    exq.push_back({8'h03, 24'h1});
    ww(1, 1);
    fb_under_uv <= 0;
    ss_at_fb <= 1;
    exq.push_back({8'h03, 24'h0});
    ww(1, 0);
    comp_clamped <= 0;
    ss_at_fb <= 0;
    wt(10);
    comp_clamped <= 1;
    ss_over_fb <= 1;
    exq.push_back({8'h03, 24'h1});
    ww(1, 1);
    comp_clamped <= 0;
    ss_over_fb <= 0;
    ss_at_fb <= 1;
    exq.push_back({8'h03, 24'h0});
    ww(1, 0);
    ss_at_fb <= 0;
    ss_ramp_done <= 1;
    wt(10);
    ss_ramp_done <= 0;
    wt(10);
    end_sim();
  end
endmodule // tb_fhs_supervisor
bind fhs_supervisor fhs_properties #(.HICCUP_CYC(HICCUP_CYC),
  .HICCUP_LONG_CYC(HICCUP_LONG_CYC)) fhs_properties_inst (.*);
`default_nettype wire
